/* File: rtl/mdc_defs.vh */
// Shared constants of the mobile DRAM channel interface.
// Holds definitions only; included by the design files by bare name.
`ifndef MDC_DEFS_VH
`define MDC_DEFS_VH

// Pin group sizes
`define MDC_CHANNELS 2
`define MDC_CA_W 6
`define MDC_DQ_W 16
`define MDC_LANES 2
`define MDC_BANKS 8
`define MDC_BANK_W 3
`define MDC_COL_W 8

// Command opcodes, first half bits [2:0]; bank or field in bits [5:3]
`define MDC_OP_NOP 3'h0
`define MDC_OP_ACT 3'h1
`define MDC_OP_WR 3'h2
`define MDC_OP_RD 3'h3
`define MDC_OP_MRW 3'h4
`define MDC_OP_RD32 3'h5
`define MDC_OP_WR32 3'h6
`define MDC_OP_PRE 3'h7

// Mode field selects for a mode write, and bit positions inside the value
`define MDC_MR_BURST 3'h0
`define MDC_MR_RL 3'h1
`define MDC_MR_WL 3'h2
`define MDC_MR_MISC 3'h3
`define MDC_BIT_BL32 0
`define MDC_BIT_OTF 1
`define MDC_BIT_DBI 0
`define MDC_BIT_CAODT 1
`define MDC_MR0_BYTE_BIT 1

// Reset values of the mode settings
`define MDC_RST_RL 4'h6
`define MDC_RST_WL 4'h4
`define MDC_RST_BL32 1'h0
`define MDC_RST_OTF 1'h0
`define MDC_RST_DBI 1'h0
`define MDC_RST_CAODT 1'h0

// Burst lengths in beats
`define MDC_BL16 6'h10
`define MDC_BL32 6'h20

// Bytes with more ones than this are sent inverted
`define MDC_DBI_LIMIT 4'h4

// Width of the synchronised input bundle of one channel
`define MDC_SYNC_W 33

`endif

/* File: rtl/mdc_mem.v */
// Per-channel storage array: byte-writable, one write and one read port.
// Assumes a single clock; read data come out of a register one cycle later.
`timescale 1ns/1ps

module mdc_mem #(
    parameter DW = 16,
    parameter AW = 13
) (
    // Clock
    input wire clk,
    // Write port
    input wire [DW/8-1:0] wr_en,
    input wire [AW-1:0] wr_addr,
    input wire [DW-1:0] wr_data,
    // Read port
    input wire rd_en,
    input wire [AW-1:0] rd_addr,
    output reg [DW-1:0] rd_data
);

reg [DW-1:0] mem [0:(1<<AW)-1];
integer i;

always @(posedge clk) begin
    for (i = 0; i < DW/8; i = i + 1) begin
        if (wr_en[i]) begin
            mem[wr_addr][8*i +: 8] <= wr_data[8*i +: 8];
        end
    end
    if (rd_en) begin
        rd_data <= mem[rd_addr];
    end
end

endmodule

/* File: rtl/mdc_dram_if.v */
// Device side of a dual-channel mobile DRAM pin interface.
// Assumes all die pins are asynchronous to clk and that the link clock
// is far slower than clk, so that each link edge is seen by sampling.
//
// Function
// - Sample inputs when true clock rises, complement falls
// - Command is two halves on six CA bits
// - Clock enable gates command capture and drivers
// - Clock enable level forms part of command
// - Chip select level forms part of command
// - Both channels run fully independently
// - Two beats per pin per clock, sixteen- or 32-beat access
// - Device drives read strobe edge-aligned with data
// - One strobe and mask line per byte
// - Mask line high marks inverted byte, disableable
// - CA termination from pin and mode setting
// - Reset pin low resets both channels
// - Activate opens bank row before access
// - Access uses bank, start column, programmed burst
// - Burst 16 default, 32 or on-the-fly
// - Programmable read and write latency
// - Mode register zero bit one reports byte mode strap
// - Two channels of eight banks each
// - Two lowest column bits are always zero
`timescale 1ns/1ps
`include "mdc_defs.vh"

module mdc_dram_if #(
    parameter ROW_W = 2
) (
    // Clock and reset
    input wire clk,
    input wire reset,
    // Die-level pins
    input wire reset_pin_n,
    input wire byte_mode_strap,
    // Command side pins, one bit or field per channel
    input wire [1:0] clock_true,
    input wire [1:0] clock_complement,
    input wire [1:0] clk_enable,
    input wire [1:0] chip_sel,
    input wire [11:0] cmd_addr_bus,
    input wire [1:0] cmd_termination_ctl,
    // Data pins
    input wire [31:0] dq_in,
    output wire [31:0] dq_out,
    output wire [31:0] dq_oe_n,
    // Strobe pins, one pair per byte lane
    input wire [3:0] dqs_t_in,
    input wire [3:0] dqs_c_in,
    output wire [3:0] dqs_t_out,
    output wire [3:0] dqs_c_out,
    output wire [3:0] dqs_oe_n,
    // Mask and inversion pins, one per byte lane
    input wire [3:0] mask_invert_line_in,
    output wire [3:0] mask_invert_line_out,
    output wire [3:0] mask_invert_line_oe_n,
    // Status
    output wire [1:0] ca_term_en,
    output wire [1:0] clock_active,
    output wire [15:0] bank_open,
    output wire [7:0] mode_reg_zero
);

localparam AW = `MDC_BANK_W + ROW_W + `MDC_COL_W;
localparam ST_IDLE = 5'b00001;
localparam ST_WR_WAIT = 5'b00010;
localparam ST_WR_DATA = 5'b00100;
localparam ST_RD_WAIT = 5'b01000;
localparam ST_RD_DATA = 5'b10000;

function [3:0] ones8;
    input [7:0] b;
    integer k;
    begin
        ones8 = 4'h0;
        for (k = 0; k < 8; k = k + 1) begin
            ones8 = ones8 + {3'h0, b[k]};
        end
    end
endfunction

// Beat address wraps inside the aligned burst block
function [7:0] col_at;
    input [7:0] col;
    input [5:0] beat;
    input bl32;
    reg [4:0] s;
    begin
        s = col[4:0] + beat[4:0];
        if (bl32) begin
            col_at = {col[7:5], s};
        end else begin
            col_at = {col[7:4], s[3:0]};
        end
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Die reset and strap

reg rn_s1_q;
reg rn_s2_q;
reg strap_done_q;
reg [7:0] mr0_q;
wire die_rst = reset | ~rn_s2_q;

always @(posedge clk) begin
    if (reset) begin
        rn_s1_q <= 1'b0;
        rn_s2_q <= 1'b0;
    end else begin
        rn_s1_q <= reset_pin_n;
        rn_s2_q <= rn_s1_q;
    end
end

// Strap caught once after the die reset lifts
always @(posedge clk) begin
    if (die_rst) begin
        strap_done_q <= 1'b0;
        mr0_q <= 8'h00;
    end else if (!strap_done_q) begin
        strap_done_q <= 1'b1;
        mr0_q[`MDC_MR0_BYTE_BIT] <= byte_mode_strap;
    end
end

assign mode_reg_zero = mr0_q;

////////////////////////////////////////////////////////////////////////////////
// Channels

genvar g;
generate
    for (g = 0; g < `MDC_CHANNELS; g = g + 1) begin : ch
        wire [`MDC_SYNC_W-1:0] raw = {clock_true[g], clock_complement[g], clk_enable[g],
            chip_sel[g], cmd_addr_bus[6*g +: 6], cmd_termination_ctl[g], dq_in[16*g +: 16],
            dqs_t_in[2*g +: 2], dqs_c_in[2*g +: 2], mask_invert_line_in[2*g +: 2]};
        reg [`MDC_SYNC_W-1:0] s1_q;
        reg [`MDC_SYNC_W-1:0] s2_q;
        reg diff_p_q;
        reg [1:0] dqs_p_q;
        reg half_q;
        reg [5:0] ca1_q;
        reg [4:0] st_q;
        reg bl32_q, otf_q, dbi_q, caodt_q;
        reg [3:0] rl_q, wl_q, lat_q;
        reg [7:0] open_q;
        reg [8*ROW_W-1:0] rows_q;
        reg [2:0] bank_q;
        reg [ROW_W-1:0] row_q;
        reg [7:0] col_q;
        reg cur32_q;
        reg [5:0] beat_q, fetch_q;
        reg pend_q;
        reg [15:0] buf0_q, buf1_q;
        reg [1:0] cnt_q;
        reg [15:0] dqo_q;
        reg [1:0] dmo_q;
        reg dqs_q;
        reg [1:0] wen_q;
        reg [AW-1:0] waddr_q;
        reg [15:0] wdata_q;
        wire [15:0] rd_word;

        // Every input passes two flops first
        always @(posedge clk) begin
            if (die_rst) begin
                s1_q <= {`MDC_SYNC_W{1'b0}};
                s2_q <= {`MDC_SYNC_W{1'b0}};
            end else begin
                s1_q <= raw;
                s2_q <= s1_q;
            end
        end

        wire ck_diff = s2_q[32] & ~s2_q[31];
        wire cke = s2_q[30];
        wire cs = s2_q[29];
        wire [5:0] ca = s2_q[28:23];
        wire [15:0] dq = s2_q[21:6];
        wire [1:0] dqs_diff = s2_q[5:4] & ~s2_q[3:2];
        wire [1:0] mask_invert_line = s2_q[1:0];
        wire ck_rise = ck_diff & ~diff_p_q;
        wire ck_edge = ck_diff ^ diff_p_q;
        wire strobe = dqs_diff[0] ^ dqs_p_q[0];
        wire [5:0] bl = cur32_q ? `MDC_BL32 : `MDC_BL16;
        wire [3:0] lat_nxt = lat_q + 4'h1;
        wire cmd_go = ck_rise & half_q & cke;
        wire [2:0] op = ca1_q[2:0];
        wire [2:0] sel = ca1_q[5:3];
        wire is_rd = (op == `MDC_OP_RD) | (op == `MDC_OP_RD32);
        wire is_wr = (op == `MDC_OP_WR) | (op == `MDC_OP_WR32);
        wire long_op = (op == `MDC_OP_RD32) | (op == `MDC_OP_WR32);
        wire acc_ok = cmd_go & (st_q == ST_IDLE) & open_q[sel];
        wire rd_start = (st_q == ST_RD_WAIT) & ck_rise & (lat_nxt >= rl_q);
        wire wr_start = (st_q == ST_WR_WAIT) & ck_rise & (lat_nxt >= wl_q);
        wire pop = rd_start | ((st_q == ST_RD_DATA) & ck_edge & (beat_q != bl));
        wire push = pend_q;
        wire buf_ready = ({1'b0, cnt_q} + {2'h0, pend_q}) < 3'h2;
        wire fetch = (fetch_q != 6'h00) & buf_ready;
        wire [15:0] head = (cnt_q == 2'h0) ? rd_word : buf0_q;
        wire [AW-1:0] faddr = {bank_q, row_q, col_at(col_q, bl - fetch_q, cur32_q)};

        always @(posedge clk) begin
            if (die_rst) begin
                diff_p_q <= 1'b0;
                dqs_p_q <= 2'b00;
            end else begin
                diff_p_q <= ck_diff;
                dqs_p_q <= dqs_diff;
            end
        end

        // Command capture: first half needs enable and select high
        always @(posedge clk) begin
            if (die_rst) begin
                half_q <= 1'b0;
                ca1_q <= 6'h00;
            end else if (ck_rise) begin
                if (half_q) begin
                    half_q <= 1'b0;
                end else if (cke & cs) begin
                    half_q <= 1'b1;
                    ca1_q <= ca;
                end
            end
        end

        // Mode settings and bank rows
        always @(posedge clk) begin
            if (die_rst) begin
                bl32_q <= `MDC_RST_BL32;
                otf_q <= `MDC_RST_OTF;
                dbi_q <= `MDC_RST_DBI;
                caodt_q <= `MDC_RST_CAODT;
                rl_q <= `MDC_RST_RL;
                wl_q <= `MDC_RST_WL;
                open_q <= 8'h00;
                rows_q <= {8*ROW_W{1'b0}};
            end else if (cmd_go & (st_q == ST_IDLE)) begin
                case (op)
                    `MDC_OP_ACT: begin
                        open_q[sel] <= 1'b1;
                        rows_q[sel*ROW_W +: ROW_W] <= ca[ROW_W-1:0];
                    end
                    `MDC_OP_PRE: begin
                        open_q[sel] <= 1'b0;
                    end
                    `MDC_OP_MRW: begin
                        case (sel)
                            `MDC_MR_BURST: begin
                                bl32_q <= ca[`MDC_BIT_BL32];
                                otf_q <= ca[`MDC_BIT_OTF];
                            end
                            `MDC_MR_RL: rl_q <= ca[3:0];
                            `MDC_MR_WL: wl_q <= ca[3:0];
                            `MDC_MR_MISC: begin
                                dbi_q <= ca[`MDC_BIT_DBI];
                                caodt_q <= ca[`MDC_BIT_CAODT];
                            end
                            default: begin
                            end
                        endcase
                    end
                    default: begin
                    end
                endcase
            end
        end

        // Access sequencer
        always @(posedge clk) begin
            if (die_rst) begin
                st_q <= ST_IDLE;
                lat_q <= 4'h0;
                beat_q <= 6'h00;
                bank_q <= 3'h0;
                row_q <= {ROW_W{1'b0}};
                col_q <= 8'h00;
                cur32_q <= 1'b0;
            end else begin
                case (st_q)
                    ST_IDLE: begin
                        lat_q <= 4'h0;
                        beat_q <= 6'h00;
                        if (acc_ok & (is_rd | is_wr)) begin
                            bank_q <= sel;
                            row_q <= rows_q[sel*ROW_W +: ROW_W];
                            col_q <= {ca, 2'b00};
                            cur32_q <= otf_q ? long_op : bl32_q;
                            st_q <= is_rd ? ST_RD_WAIT : ST_WR_WAIT;
                        end
                    end
                    ST_WR_WAIT: begin
                        if (wr_start) begin
                            st_q <= ST_WR_DATA;
                        end else if (ck_rise) begin
                            lat_q <= lat_nxt;
                        end
                    end
                    ST_WR_DATA: begin
                        if (beat_q == bl) begin
                            st_q <= ST_IDLE;
                        end else if (strobe) begin
                            beat_q <= beat_q + 6'h01;
                        end
                    end
                    ST_RD_WAIT: begin
                        if (rd_start) begin
                            st_q <= ST_RD_DATA;
                            beat_q <= 6'h01;
                        end else if (ck_rise) begin
                            lat_q <= lat_nxt;
                        end
                    end
                    ST_RD_DATA: begin
                        if (ck_edge) begin
                            if (beat_q == bl) begin
                                st_q <= ST_IDLE;
                            end else begin
                                beat_q <= beat_q + 6'h01;
                            end
                        end
                    end
                    default: st_q <= ST_IDLE;
                endcase
            end
        end

        // Prefetch into the two-entry buffer; fetch stalls while it is full
        always @(posedge clk) begin
            if (die_rst) begin
                fetch_q <= 6'h00;
                pend_q <= 1'b0;
                cnt_q <= 2'h0;
                buf0_q <= 16'h0000;
                buf1_q <= 16'h0000;
            end else begin
                if (acc_ok & is_rd) begin
                    fetch_q <= (otf_q ? long_op : bl32_q) ? `MDC_BL32 : `MDC_BL16;
                end else if (fetch) begin
                    fetch_q <= fetch_q - 6'h01;
                end
                pend_q <= fetch;
                case ({push, pop & ((cnt_q != 2'h0) | push)})
                    2'b10: begin
                        if (cnt_q == 2'h0) begin
                            buf0_q <= rd_word;
                        end else begin
                            buf1_q <= rd_word;
                        end
                        cnt_q <= cnt_q + 2'h1;
                    end
                    2'b01: begin
                        buf0_q <= buf1_q;
                        cnt_q <= cnt_q - 2'h1;
                    end
                    2'b11: begin
                        if (cnt_q == 2'h2) begin
                            buf0_q <= buf1_q;
                            buf1_q <= rd_word;
                        end else if (cnt_q == 2'h1) begin
                            buf0_q <= rd_word;
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end

        // Read beats: data and strobe change on the same link edge
        always @(posedge clk) begin
            if (die_rst) begin
                dqo_q <= 16'h0000;
                dmo_q <= 2'b00;
                dqs_q <= 1'b0;
            end else if (pop) begin
                dqs_q <= ~dqs_q;
                if (dbi_q & (ones8(head[7:0]) > `MDC_DBI_LIMIT)) begin
                    dqo_q[7:0] <= ~head[7:0];
                    dmo_q[0] <= 1'b1;
                end else begin
                    dqo_q[7:0] <= head[7:0];
                    dmo_q[0] <= 1'b0;
                end
                if (dbi_q & (ones8(head[15:8]) > `MDC_DBI_LIMIT)) begin
                    dqo_q[15:8] <= ~head[15:8];
                    dmo_q[1] <= 1'b1;
                end else begin
                    dqo_q[15:8] <= head[15:8];
                    dmo_q[1] <= 1'b0;
                end
            end else if (st_q == ST_IDLE) begin
                dqs_q <= 1'b0;
            end
        end

        // Write beats: inverted bytes restored, masked bytes dropped
        always @(posedge clk) begin
            if (die_rst) begin
                wen_q <= 2'b00;
                waddr_q <= {AW{1'b0}};
                wdata_q <= 16'h0000;
            end else begin
                wen_q <= 2'b00;
                if ((st_q == ST_WR_DATA) & strobe & (beat_q != bl)) begin
                    waddr_q <= {bank_q, row_q, col_at(col_q, beat_q, cur32_q)};
                    wdata_q[7:0] <= (dbi_q & mask_invert_line[0]) ? ~dq[7:0] : dq[7:0];
                    wdata_q[15:8] <= (dbi_q & mask_invert_line[1]) ? ~dq[15:8] : dq[15:8];
                    wen_q <= dbi_q ? 2'b11 : ~mask_invert_line;
                end
            end
        end

        mdc_mem #(
            .DW(16),
            .AW(AW)
        ) u_mem (
            .clk(clk),
            .wr_en(wen_q),
            .wr_addr(waddr_q),
            .wr_data(wdata_q),
            .rd_en(fetch),
            .rd_addr(faddr),
            .rd_data(rd_word)
        );

        // Drivers only while reading with clock enable high
        wire drive = (st_q == ST_RD_DATA) & cke;
        assign dq_out[16*g +: 16] = dqo_q;
        assign dq_oe_n[16*g +: 16] = {16{~drive}};
        assign dqs_t_out[2*g +: 2] = {2{dqs_q}};
        assign dqs_c_out[2*g +: 2] = {2{~dqs_q}};
        assign dqs_oe_n[2*g +: 2] = {2{~drive}};
        assign mask_invert_line_out[2*g +: 2] = dmo_q;
        assign mask_invert_line_oe_n[2*g +: 2] = {2{~(drive & dbi_q)}};
        assign ca_term_en[g] = s2_q[22] & caodt_q;
        assign clock_active[g] = cke;
        assign bank_open[8*g +: 8] = open_q;
    end
endgenerate

endmodule

/* File: bench/mdc_dram_if_asserts.sv */
// Checker for the mobile DRAM channel interface, bound to mdc_dram_if.
// Sees only the top ports; single clk domain, reset synchronous high.
`timescale 1ns/1ps

module mdc_dram_if_chk (
    // Clock and reset
    input wire clk,
    input wire reset,
    input wire reset_pin_n,
    // Command pins
    input wire [1:0] clock_true,
    input wire [1:0] clk_enable,
    input wire [1:0] cmd_termination_ctl,
    // Data and strobe outputs
    input wire [31:0] dq_out,
    input wire [31:0] dq_oe_n,
    input wire [3:0] dqs_t_out,
    input wire [3:0] dqs_c_out,
    input wire [3:0] dqs_oe_n,
    input wire [3:0] mask_invert_line_oe_n,
    // Status
    input wire [1:0] ca_term_en,
    input wire [1:0] clock_active,
    input wire [15:0] bank_open,
    input wire [7:0] mode_reg_zero
);
    // Cycles since any reset, saturating
    logic [3:0] settle_q;
    always @(posedge clk) begin
        if (reset || !reset_pin_n)
            settle_q <= 4'h0;
        else if (settle_q != 4'h8)
            settle_q <= settle_q + 4'h1;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    property p_strobe_pair;
        dqs_c_out == ~dqs_t_out;
    endproperty
    a_strobe_pair: assert property (p_strobe_pair) else $error("strobe pair split");
    property p_lane_oe;
        dq_oe_n == {{8{dqs_oe_n[3]}}, {8{dqs_oe_n[2]}}, {8{dqs_oe_n[1]}}, {8{dqs_oe_n[0]}}};
    endproperty
    a_lane_oe: assert property (p_lane_oe) else $error("lane enables differ");
    property p_cke_level;
        (settle_q == 4'h8 && $stable(clk_enable)) [*4] |-> clock_active == clk_enable;
    endproperty
    a_cke_level: assert property (p_cke_level) else $error("clock active wrong");
    property p_term_off;
        !cmd_termination_ctl[0] [*5] |-> !ca_term_en[0];
    endproperty
    a_term_off: assert property (p_term_off) else $error("termination without pin");
    property p_pin_reset;
        !reset_pin_n [*5] |-> bank_open == 16'h0000 && &dqs_oe_n && mode_reg_zero == 8'h00;
    endproperty
    a_pin_reset: assert property (p_pin_reset) else $error("pin reset ignored");
    property p_mr0;
        settle_q == 4'h8 |-> $stable(mode_reg_zero) && mode_reg_zero[7:2] == 6'h00
            && !mode_reg_zero[0];
    endproperty
    a_mr0: assert property (p_mr0) else $error("mode reg zero wrong");
    property p_bank_quiet;
        ($stable(clock_true) && reset_pin_n) [*6] |-> $stable(bank_open);
    endproperty
    a_bank_quiet: assert property (p_bank_quiet) else $error("bank change no link");
    property p_read_start;
        $fell(dqs_oe_n[0]) |-> dqs_t_out[0] && !dq_oe_n[0];
    endproperty
    a_read_start: assert property (p_read_start) else $error("read start strobe");
    property p_edge_align;
        !dqs_oe_n[0] && $changed(dq_out[7:0]) |-> $changed(dqs_t_out[0]);
    endproperty
    a_edge_align: assert property (p_edge_align) else $error("data without strobe");
    property p_mask_oe;
        !mask_invert_line_oe_n[0] |-> !dqs_oe_n[0];
    endproperty
    a_mask_oe: assert property (p_mask_oe) else $error("mask driven not reading");
    c_read: cover property ($fell(dqs_oe_n[0]));
    c_bank: cover property ($rose(bank_open[3]));
    c_term: cover property ($rose(ca_term_en[0]));
endmodule

bind mdc_dram_if mdc_dram_if_chk mdc_dram_if_chk_inst (.clk, .reset, .reset_pin_n,
    .clock_true, .clk_enable, .cmd_termination_ctl, .dq_out, .dq_oe_n, .dqs_t_out,
    .dqs_c_out, .dqs_oe_n, .mask_invert_line_oe_n, .ca_term_en, .clock_active,
    .bank_open, .mode_reg_zero);

/* File: bench/mdc_ctl_model.sv */
// Controller model: link clock, commands and write bursts.
// Tasks are called 1 ns after a clk edge; link half period is 40 ns.
`timescale 1ns/1ps

module mdc_ctl_model (
    // Command pins
    output logic [1:0] clock_true,
    output logic [1:0] clock_complement,
    output logic [1:0] chip_sel,
    output logic [11:0] cmd_addr_bus,
    // Write pins
    output logic [31:0] dq_m,
    output logic [3:0] dqs_t_m,
    output logic [3:0] dqs_c_m,
    output logic [3:0] mask_m
);
    initial begin
        clock_true = 2'b00;
        clock_complement = 2'b11;
        chip_sel = 2'b00;
        cmd_addr_bus = 12'h000;
        dq_m = 32'h0000_0000;
        dqs_t_m = 4'h0;
        dqs_c_m = 4'hf;
        mask_m = 4'h0;
    end
    // Link clock edges; stands still between calls
    task automatic tog(input int ch, input int n);
        repeat (n) begin
            clock_true[ch] = ~clock_true[ch];
            clock_complement[ch] = ~clock_true[ch];
            #40;
        end
    endtask
    task automatic cmd(input int ch, input logic cs, input logic [2:0] op,
        input logic [2:0] f, input logic [5:0] arg);
        chip_sel[ch] = cs;
        cmd_addr_bus[6*ch +: 6] = {f, op};
        tog(ch, 2);
        chip_sel[ch] = 1'b0;
        cmd_addr_bus[6*ch +: 6] = arg;
        tog(ch, 2);
        cmd_addr_bus[6*ch +: 6] = ~arg;
    endtask
    // Sixteen beats, strobe edge centred in each eye
    task automatic wr(input int ch, input int wl, input logic [255:0] d);
        tog(ch, 2 * wl);
        for (int k = 0; k < 16; k++) begin
            dq_m[16*ch +: 16] = d[16*k +: 16];
            #20;
            dqs_t_m[2*ch +: 2] = ~dqs_t_m[2*ch +: 2];
            dqs_c_m[2*ch +: 2] = ~dqs_t_m[2*ch +: 2];
            #20;
        end
        dq_m[16*ch +: 16] = ~dq_m[16*ch +: 16];
    endtask
endmodule

/* File: bench/tb.sv */
// Testbench of mdc_dram_if with the controller model on the pins.
// Inputs change 1 ns after clk; link edges checked 40 ns later.
`timescale 1ns/1ps
`include "mdc_defs.vh"

module tb;
    localparam int RL = 3;
    localparam int WL = 2;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic reset_pin_n = 1'b1;
    logic [1:0] clk_enable = 2'b00;
    logic [1:0] term = 2'b00;
    int err_total = 0;
    int n_compared = 0;
    int cyc = 0;
    wire [1:0] ck_t, ck_c, cs, ca_term_en, clock_active;
    wire [11:0] ca;
    wire [31:0] dq_m, dq_out, dq_oe_n, dq_w;
    wire [3:0] st_m, sc_m, mk_m, st_o, sc_o, s_oe, mk_o, mk_oe;
    wire [15:0] bank_open;
    wire [7:0] mode_reg_zero;
    // Wire level of the shared pins
    assign dq_w = (dq_out & ~dq_oe_n) | (dq_m & dq_oe_n);
    mdc_ctl_model mdc_ctl_model_inst (.clock_true(ck_t), .clock_complement(ck_c),
        .chip_sel(cs), .cmd_addr_bus(ca), .dq_m(dq_m), .dqs_t_m(st_m), .dqs_c_m(sc_m),
        .mask_m(mk_m));
    mdc_dram_if #(.ROW_W(2)) mdc_dram_if_inst (.clk(clk), .reset(reset),
        .reset_pin_n(reset_pin_n), .byte_mode_strap(1'b1), .clock_true(ck_t),
        .clock_complement(ck_c), .clk_enable(clk_enable), .chip_sel(cs), .cmd_addr_bus(ca),
        .cmd_termination_ctl(term), .dq_in(dq_w), .dq_out(dq_out), .dq_oe_n(dq_oe_n),
        .dqs_t_in((st_o & ~s_oe) | (st_m & s_oe)), .dqs_c_in((sc_o & ~s_oe) | (sc_m & s_oe)),
        .dqs_t_out(st_o), .dqs_c_out(sc_o), .dqs_oe_n(s_oe),
        .mask_invert_line_in((mk_o & ~mk_oe) | (mk_m & mk_oe)),
        .mask_invert_line_out(mk_o), .mask_invert_line_oe_n(mk_oe), .ca_term_en(ca_term_en),
        .clock_active(clock_active), .bank_open(bank_open), .mode_reg_zero(mode_reg_zero));
    initial forever #5 clk = ~clk;
    task automatic chk(input string what, input logic [39:0] seen, input logic [39:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    function automatic logic [15:0] word(input int k);
        return {4'(k), 4'(k), 8'h01 << k[2:0]};
    endfunction
    task automatic cmd0(input logic [2:0] op, input logic [2:0] f, input logic [5:0] a);
        mdc_ctl_model_inst.cmd(0, 1'b1, op, f, a);
    endtask
    task automatic rd(input logic [5:0] a, input logic dbi);
        logic [15:0] e;
        logic [1:0] m;
        cmd0(`MDC_OP_RD, 3'h3, a);
        mdc_ctl_model_inst.tog(0, 2 * RL - 2);
        for (int k = 0; k < 16; k++) begin
            e = word((int'(a) * 4 + k) % 16);
            m = 2'b00;
            for (int b = 0; b < 2; b++) begin
                if (dbi && $countones(e[8*b +: 8]) > 4) begin
                    e[8*b +: 8] = ~e[8*b +: 8];
                    m[b] = 1'b1;
                end
            end
            mdc_ctl_model_inst.tog(0, 1);
            chk("read word", dq_out[15:0], e);
            chk("read strobe", {sc_o[1:0], st_o[1:0]}, (k % 2 == 0) ? 4'h3 : 4'hc);
            chk("read drive", {s_oe, dq_oe_n[31:16], dq_oe_n[15:0]}, 36'hc_ffff_0000);
            chk("read invert", {mk_oe[1:0], mk_o[1:0]}, {dbi ? 2'b00 : 2'b11, m});
        end
        mdc_ctl_model_inst.tog(0, 2);
        chk("read release", {s_oe, dq_oe_n[15:0]}, 20'hf_ffff);
    endtask
    task automatic t_main();
        logic [255:0] d;
        chk("reset drive", {s_oe, mk_oe, bank_open}, 24'hff_0000);
        chk("mode zero", mode_reg_zero, 8'h02);
        clk_enable = 2'b01;
        term = 2'b11;
        step(6);
        chk("cke", clock_active, 2'b01);
        chk("term off", ca_term_en, 2'b00);
        clk_enable = 2'b11;
        cmd0(`MDC_OP_MRW, `MDC_MR_MISC, 6'h02);
        cmd0(`MDC_OP_MRW, `MDC_MR_RL, 6'(RL));
        cmd0(`MDC_OP_MRW, `MDC_MR_WL, 6'(WL));
        chk("term on", ca_term_en, 2'b01);
        $display("done setup");
        mdc_ctl_model_inst.cmd(0, 1'b0, `MDC_OP_ACT, 3'h2, 6'h01);
        chk("no select", bank_open, 16'h0000);
        clk_enable = 2'b10;
        cmd0(`MDC_OP_ACT, 3'h5, 6'h01);
        clk_enable = 2'b11;
        chk("cke low", bank_open, 16'h0000);
        cmd0(`MDC_OP_ACT, 3'h3, 6'h01);
        mdc_ctl_model_inst.cmd(1, 1'b1, `MDC_OP_ACT, 3'h7, 6'h02);
        chk("activate", bank_open, 16'h8008);
        $display("done activate");
        for (int k = 0; k < 16; k++)
            d[16*k +: 16] = word(k);
        cmd0(`MDC_OP_WR, 3'h3, 6'h00);
        mdc_ctl_model_inst.wr(0, WL, d);
        step(4);
        rd(6'h02, 1'b0);
        $display("done rw");
        cmd0(`MDC_OP_MRW, `MDC_MR_MISC, 6'h03);
        rd(6'h00, 1'b1);
        $display("done inversion");
        cmd0(`MDC_OP_PRE, 3'h3, 6'h00);
        chk("pre", bank_open, 16'h8000);
        reset_pin_n = 1'b0;
        step(6);
        reset_pin_n = 1'b1;
        step(6);
        chk("pin reset", {bank_open, mode_reg_zero}, 24'h0000_02);
        $display("done pin reset");
    endtask
    task automatic close_out();
        $display("compared %0d mismatched %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            close_out();
        end
    end
    initial begin
        step(6);
        reset = 1'b0;
        step(8);
        t_main();
        close_out();
    end
endmodule
